// ==== common/ccr_pkg.sv ====
// Constants, field layout and types for the channel configuration registers
package ccr_pkg;

    // Avalon-MM geometry
    localparam int CCR_ADDR_W = 10;
    localparam int CCR_DATA_W = 32;
    localparam int CCR_BE_W = 4;
    localparam int CCR_REG_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [7:0] CCR_IDX_CONFIG = 8'h22;
    localparam logic [7:0] CCR_IDX_OCAL_HIGH = 8'h23;
    localparam logic [7:0] CCR_IDX_OCAL_LOW = 8'h24;
    localparam logic [1:0] CCR_WORD_ALIGN = 2'h0;

    // Configuration register fields
    localparam int CCR_PHASE_MSB = 15;
    localparam int CCR_PHASE_LSB = 6;
    localparam int CCR_PHASE_W = 10;
    localparam int CCR_DCOVR_BIT = 2;
    localparam int CCR_SEL_MSB = 1;
    localparam int CCR_SEL_LSB = 0;
    localparam logic [15:0] CCR_CONFIG_WMASK = 16'hFFC7;
    localparam logic [15:0] CCR_CONFIG_RESET = 16'h0000;

    // Offset calibration fields
    localparam int CCR_OCAL_W = 24;
    localparam int CCR_OCAL_LOW_MSB = 15;
    localparam int CCR_OCAL_LOW_LSB = 8;
    localparam logic [15:0] CCR_OCAL_HIGH_WMASK = 16'hFFFF;
    localparam logic [15:0] CCR_OCAL_LOW_WMASK = 16'hFF00;
    localparam logic [15:0] CCR_OCAL_HIGH_RESET = 16'h0000;
    localparam logic [15:0] CCR_OCAL_LOW_RESET = 16'h0000;

    // Global DC filter setting width; zero means filter off
    localparam int CCR_DCF_W = 4;
    localparam logic [3:0] CCR_DCF_OFF = 4'h0;

    // Avalon response codes
    localparam logic [1:0] CCR_RESP_OKAY = 2'h0;
    localparam logic [1:0] CCR_RESP_DECODEERROR = 2'h3;

    typedef enum logic [1:0] {
        CCR_SEL_PINS = 2'h0,
        CCR_SEL_SHORTED = 2'h1,
        CCR_SEL_TEST_POS = 2'h2,
        CCR_SEL_TEST_NEG = 2'h3
    } ccr_input_sel_e;

    typedef enum logic {
        CCR_BUS_IDLE,
        CCR_BUS_ANSWER
    } ccr_bus_state_e;

    // Byte address of a register index
    function automatic logic [9:0] ccr_addr(input logic [7:0] idx);
        ccr_addr = {idx, CCR_WORD_ALIGN};
    endfunction : ccr_addr

endpackage : ccr_pkg

// ==== common/ccr_cal_if.sv ====
// Carrier between the register bank and its offset correction unit
`timescale 1ns/100ps
interface ccr_cal_if;
    import ccr_pkg::*;

    logic [CCR_OCAL_W-1:0] offset;
    logic [CCR_OCAL_W-1:0] sample;
    logic sample_valid;
    logic [CCR_OCAL_W-1:0] result;
    logic result_valid;

    modport regs (
        output offset,
        output sample,
        output sample_valid,
        input result,
        input result_valid
    );

    modport corr (
        input offset,
        input sample,
        input sample_valid,
        output result,
        output result_valid
    );
endinterface : ccr_cal_if

// ==== rtl/ccr_offset_corr.sv ====
// Signed offset correction of conversion results, saturating at full scale
`timescale 1ns/100ps
module ccr_offset_corr
    import ccr_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Calibration carrier
    ccr_cal_if.corr cal
);

    localparam logic [CCR_OCAL_W-1:0] MAX_POS = {1'b0, {(CCR_OCAL_W-1){1'b1}}};
    localparam logic [CCR_OCAL_W-1:0] MAX_NEG = {1'b1, {(CCR_OCAL_W-1){1'b0}}};

    logic [CCR_OCAL_W-1:0] result_q;
    logic [CCR_OCAL_W-1:0] result_d;
    logic valid_q;
    logic valid_d;

    always_comb begin
        logic signed [CCR_OCAL_W:0] diff;
        diff = '0;
        // Both operands are two's complement; one guard bit shows overflow
        diff = $signed({cal.sample[CCR_OCAL_W-1], cal.sample})
             - $signed({cal.offset[CCR_OCAL_W-1], cal.offset});
        if (diff[CCR_OCAL_W] != diff[CCR_OCAL_W-1]) begin
            result_d = diff[CCR_OCAL_W] ? MAX_NEG : MAX_POS;
        end else begin
            result_d = diff[CCR_OCAL_W-1:0];
        end
        if (!cal.sample_valid) begin
            result_d = result_q;
        end
        valid_d = cal.sample_valid;
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            result_q <= '0;
            valid_q <= 1'b0;
        end else begin
            result_q <= result_d;
            valid_q <= valid_d;
        end
    end

    assign cal.result = result_q;
    assign cal.result_valid = valid_q;

endmodule : ccr_offset_corr

// ==== rtl/ccr_channel_regs.sv ====
// Channel configuration and offset calibration register bank, Avalon-MM slave
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module ccr_channel_regs
    import ccr_pkg::*;
#(
    parameter logic [CCR_OCAL_W-1:0] TEST_LEVEL = 24'h100000
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Avalon-MM slave
    input wire logic [CCR_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [CCR_DATA_W-1:0] i_avs_writedata,
    input wire logic [CCR_BE_W-1:0] i_avs_byteenable,
    output logic [CCR_DATA_W-1:0] o_avs_readdata,
    output logic [1:0] o_avs_response,
    output logic o_avs_waitrequest,
    // Global filter setting and conversion stream
    input wire logic [CCR_DCF_W-1:0] i_global_dc_filter_setting,
    input wire logic [CCR_OCAL_W-1:0] i_pin_sample,
    input wire logic i_pin_sample_valid,
    // Channel controls
    output logic [CCR_PHASE_W-1:0] o_phase_delay,
    output logic [CCR_DCF_W-1:0] o_dc_filter_setting,
    output logic [1:0] o_input_selector,
    output logic [CCR_OCAL_W-1:0] o_offset_cal,
    // Corrected results
    output logic [CCR_OCAL_W-1:0] o_result,
    output logic o_result_valid
);

    localparam logic [CCR_ADDR_W-1:0] ADDR_CONFIG = ccr_addr(CCR_IDX_CONFIG);
    localparam logic [CCR_ADDR_W-1:0] ADDR_OCAL_HIGH =
        ccr_addr(CCR_IDX_OCAL_HIGH);
    localparam logic [CCR_ADDR_W-1:0] ADDR_OCAL_LOW =
        ccr_addr(CCR_IDX_OCAL_LOW);
    localparam logic [CCR_OCAL_W-1:0] ZERO_LEVEL = '0;

    // Byte-lane write merge; masked bits keep their old value
    function automatic logic [CCR_REG_W-1:0] merge_write(
        input logic [CCR_REG_W-1:0] old_val,
        input logic [CCR_DATA_W-1:0] wdata,
        input logic [CCR_BE_W-1:0] be,
        input logic [CCR_REG_W-1:0] wmask
    );
        logic [CCR_REG_W-1:0] lanes;
        logic [CCR_REG_W-1:0] keep;
        lanes = {{8{be[1]}}, {8{be[0]}}};
        keep = ~(lanes & wmask);
        merge_write = (old_val & keep) | (wdata[CCR_REG_W-1:0] & ~keep);
    endfunction : merge_write

    // One-hot register hit of an address, or zero if not mapped
    function automatic logic [2:0] decode(
        input logic [CCR_ADDR_W-1:0] addr
    );
        decode = {addr == ADDR_CONFIG, addr == ADDR_OCAL_HIGH,
                  addr == ADDR_OCAL_LOW};
    endfunction : decode

    // Bus state
    ccr_bus_state_e state_q;
    ccr_bus_state_e state_d;
    logic [CCR_DATA_W-1:0] rdata_q;
    logic [CCR_DATA_W-1:0] rdata_d;
    logic [1:0] resp_q;
    logic [1:0] resp_d;

    // Register storage
    logic [CCR_REG_W-1:0] config_q;
    logic [CCR_REG_W-1:0] config_d;
    logic [CCR_REG_W-1:0] ocal_high_q;
    logic [CCR_REG_W-1:0] ocal_high_d;
    logic [CCR_REG_W-1:0] ocal_low_q;
    logic [CCR_REG_W-1:0] ocal_low_d;

    // Channel control outputs and input path
    logic [CCR_DCF_W-1:0] dcf_q;
    logic [CCR_DCF_W-1:0] dcf_d;
    logic [CCR_OCAL_W-1:0] sample_q;
    logic [CCR_OCAL_W-1:0] sample_d;
    logic sample_vld_q;
    logic sample_vld_d;

    logic req;
    logic [2:0] hit;
    logic [CCR_REG_W-1:0] rd_word;
    ccr_input_sel_e sel;

    ccr_cal_if cal ();

    assign req = i_avs_read | i_avs_write;
    assign hit = decode(i_avs_address);
    assign sel = ccr_input_sel_e'(config_q[CCR_SEL_MSB:CCR_SEL_LSB]);

    // Reserved bits are held at zero and masked off again here, so a read shows them as zero
    always_comb begin
        rd_word = '0;
        unique case (1'b1)
            hit[2]: rd_word = config_q & CCR_CONFIG_WMASK;
            hit[1]: rd_word = ocal_high_q;
            hit[0]: rd_word = ocal_low_q & CCR_OCAL_LOW_WMASK;
            default: rd_word = '0;
        endcase
    end

    // One wait cycle per access: request seen, then answered
    assign o_avs_waitrequest = req & (state_q == CCR_BUS_IDLE);

    always_comb begin
        state_d = state_q;
        rdata_d = rdata_q;
        resp_d = resp_q;
        unique case (state_q)
            CCR_BUS_IDLE: begin
                if (req) begin
                    state_d = CCR_BUS_ANSWER;
                    resp_d = (hit != 3'h0) ? CCR_RESP_OKAY
                                           : CCR_RESP_DECODEERROR;
                    rdata_d = i_avs_read
                            ? {{(CCR_DATA_W-CCR_REG_W){1'b0}}, rd_word}
                            : '0;
                end
            end
            CCR_BUS_ANSWER: begin
                state_d = CCR_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= CCR_BUS_IDLE;
            rdata_q <= '0;
            resp_q <= CCR_RESP_OKAY;
        end else begin
            state_q <= state_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
        end
    end

    // Writes take effect on the edge that ends the access
    always_comb begin
        logic wr_now;
        wr_now = '0;
        wr_now = i_avs_write & (state_q == CCR_BUS_ANSWER);
        config_d = config_q;
        ocal_high_d = ocal_high_q;
        ocal_low_d = ocal_low_q;
        if (wr_now && hit[2]) begin
            config_d = merge_write(config_q, i_avs_writedata,
                                   i_avs_byteenable,
                                   CCR_CONFIG_WMASK);
        end
        if (wr_now && hit[1]) begin
            ocal_high_d = merge_write(ocal_high_q, i_avs_writedata,
                                      i_avs_byteenable,
                                      CCR_OCAL_HIGH_WMASK);
        end
        if (wr_now && hit[0]) begin
            ocal_low_d = merge_write(ocal_low_q, i_avs_writedata,
                                     i_avs_byteenable,
                                     CCR_OCAL_LOW_WMASK);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            config_q <= CCR_CONFIG_RESET;
            ocal_high_q <= CCR_OCAL_HIGH_RESET;
            ocal_low_q <= CCR_OCAL_LOW_RESET;
        end else begin
            config_q <= config_d;
            ocal_high_q <= ocal_high_d;
            ocal_low_q <= ocal_low_d;
        end
    end

    // Input selection and DC filter override
    always_comb begin
        dcf_d = config_q[CCR_DCOVR_BIT] ? CCR_DCF_OFF
                                        : i_global_dc_filter_setting;
        sample_vld_d = i_pin_sample_valid;
        sample_d = sample_q;
        if (i_pin_sample_valid) begin
            unique case (sel)
                CCR_SEL_PINS: sample_d = i_pin_sample;
                CCR_SEL_SHORTED: sample_d = ZERO_LEVEL;
                CCR_SEL_TEST_POS: sample_d = TEST_LEVEL;
                CCR_SEL_TEST_NEG: sample_d = ZERO_LEVEL - TEST_LEVEL;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dcf_q <= CCR_DCF_OFF;
            sample_q <= '0;
            sample_vld_q <= 1'b0;
        end else begin
            dcf_q <= dcf_d;
            sample_q <= sample_d;
            sample_vld_q <= sample_vld_d;
        end
    end

    // Offset is applied as one signed 24-bit word
    assign cal.offset = {ocal_high_q,
        ocal_low_q[CCR_OCAL_LOW_MSB:CCR_OCAL_LOW_LSB]};
    assign cal.sample = sample_q;
    assign cal.sample_valid = sample_vld_q;

    ccr_offset_corr u_corr (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .cal(cal.corr)
    );

    assign o_avs_readdata = rdata_q;
    assign o_avs_response = resp_q;
    assign o_phase_delay = config_q[CCR_PHASE_MSB:CCR_PHASE_LSB];
    assign o_dc_filter_setting = dcf_q;
    assign o_input_selector = config_q[CCR_SEL_MSB:CCR_SEL_LSB];
    assign o_offset_cal = cal.offset;
    assign o_result = cal.result;
    assign o_result_valid = cal.result_valid;

endmodule : ccr_channel_regs

// ==== verification/ccr_channel_regs_chk.sv ====
// Port assertions for the channel register bank
`timescale 1ns/100ps
module ccr_chk
    import ccr_pkg::*;
(
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    // Bus and stream
    input wire logic [CCR_ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [CCR_DATA_W-1:0] i_avs_writedata,
    input wire logic [CCR_BE_W-1:0] i_avs_byteenable,
    input wire logic [CCR_DATA_W-1:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_pin_sample_valid,
    // Channel controls and result valid
    input wire logic [CCR_PHASE_W-1:0] o_phase_delay,
    input wire logic [CCR_DCF_W-1:0] o_dc_filter_setting,
    input wire logic [1:0] o_input_selector,
    input wire logic [CCR_OCAL_W-1:0] o_offset_cal,
    input wire logic o_result_valid
);
    localparam logic [CCR_ADDR_W-1:0] A_CFG = ccr_addr(CCR_IDX_CONFIG);
    localparam logic [CCR_ADDR_W-1:0] A_HIGH = ccr_addr(CCR_IDX_OCAL_HIGH);
    localparam logic [CCR_ADDR_W-1:0] A_LOW = ccr_addr(CCR_IDX_OCAL_LOW);
    logic wr_ok;
    logic rd_ok;
    assign wr_ok = i_avs_write & ~o_avs_waitrequest;
    assign rd_ok = i_avs_read & ~o_avs_waitrequest;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_rst_n);
    sequence s_ovr_set;
        wr_ok && i_avs_address == A_CFG && i_avs_byteenable[0]
            && i_avs_writedata[CCR_DCOVR_BIT];
    endsequence
    sequence s_wr_cfg;
        wr_ok && i_avs_address == A_CFG;
    endsequence
    phase_write_a: assert property (
        s_wr_cfg ##0 (i_avs_byteenable[1:0] == 2'h3)
        |=> o_phase_delay
            == $past(i_avs_writedata[CCR_PHASE_MSB:CCR_PHASE_LSB]))
        else $error("phase delay not taken from write");
    dc_override_a: assert property (
        s_ovr_set |-> ##2 o_dc_filter_setting == CCR_DCF_OFF)
        else $error("dc filter not forced off");
    sel_write_a: assert property (
        s_wr_cfg ##0 i_avs_byteenable[0]
        |=> o_input_selector
            == $past(i_avs_writedata[CCR_SEL_MSB:CCR_SEL_LSB]))
        else $error("input selector not taken from write");
    ocal_high_a: assert property (
        wr_ok && i_avs_address == A_HIGH && i_avs_byteenable[1:0] == 2'h3
        |=> o_offset_cal[23:8] == $past(i_avs_writedata[15:0]))
        else $error("offset upper bits wrong");
    ocal_low_a: assert property (
        wr_ok && i_avs_address == A_LOW && i_avs_byteenable[1]
        |=> o_offset_cal[7:0] == $past(i_avs_writedata[15:8]))
        else $error("offset lower bits wrong");
    result_delay_a: assert property (
        i_pin_sample_valid |-> ##2 o_result_valid)
        else $error("result valid late or missing");
    cfg_rsv_a: assert property (
        rd_ok && i_avs_address == A_CFG
        |-> o_avs_readdata[5:3] == 3'h0 && o_avs_readdata[31:16] == 16'h0)
        else $error("config reserved bits not zero");
    low_rsv_a: assert property (
        rd_ok && i_avs_address == A_LOW |-> o_avs_readdata[7:0] == 8'h00)
        else $error("offset low reserved byte not zero");
endmodule : ccr_chk
bind ccr_channel_regs ccr_chk u_chk (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_avs_address(i_avs_address),
    .i_avs_read(i_avs_read),
    .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata),
    .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata),
    .o_avs_waitrequest(o_avs_waitrequest),
    .i_pin_sample_valid(i_pin_sample_valid),
    .o_phase_delay(o_phase_delay),
    .o_dc_filter_setting(o_dc_filter_setting),
    .o_input_selector(o_input_selector),
    .o_offset_cal(o_offset_cal),
    .o_result_valid(o_result_valid)
);

// ==== verification/ccr_channel_regs_tb_top.sv ====
// Self-checking bench for the channel register bank
`timescale 1ns/100ps
module ccr_channel_regs_tb_top;
    import ccr_pkg::*;
    localparam logic [23:0] TL = 24'h100000;
    logic clk, rst_n, rd, wr, sv, rv, wq;
    logic [9:0] adr, ph;
    logic [31:0] wd, rdat, got;
    logic [3:0] be, gdc, dcf;
    logic [1:0] resp, sel, gresp;
    logic [23:0] smp, ocal, res;
    logic [23:0] ofs [3] = '{24'h000010, 24'h800000, 24'h7FFFFF};
    logic [23:0] sps [3] = '{24'hFFFF00, 24'h7FFFFF, 24'h800000};
    int failures = 0;
    int total_checks = 0;

    ccr_channel_regs #(.TEST_LEVEL(TL)) DUT (
        .i_ref_clk(clk), .i_rst_n(rst_n),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdat), .o_avs_response(resp),
        .o_avs_waitrequest(wq), .i_global_dc_filter_setting(gdc),
        .i_pin_sample(smp), .i_pin_sample_valid(sv),
        .o_phase_delay(ph), .o_dc_filter_setting(dcf),
        .o_input_selector(sel), .o_offset_cal(ocal),
        .o_result(res), .o_result_valid(rv)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string n, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk

    // Request held until waitrequest is seen low at a rising edge
    task automatic acc(input logic w, input logic [9:0] a,
                       input logic [15:0] d, input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wd <= {16'hA5A5, d};
        be <= b;
        wr <= w;
        rd <= ~w;
        // Waitrequest is settled mid-cycle; low there marks the next
        // rising edge as the answer edge
        @(negedge clk);
        while (wq !== 1'b0 && n < 50) begin
            n++;
            @(negedge clk);
        end
        if (n == 50) failures++;
        @(posedge clk);
        got = rdat;
        gresp = resp;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : acc

    task automatic rdc(input logic [9:0] a, input logic [15:0] e,
                       input logic [1:0] r);
        acc(1'b0, a, 16'h0000, 4'hF);
        chk("readdata", got, {16'h0000, e});
        chk("response", {30'h0, gresp}, {30'h0, r});
    endtask : rdc

    function automatic logic [23:0] exp_res(input logic [1:0] m,
                                            input logic [23:0] s, o);
        logic signed [24:0] v;
        logic [23:0] src;
        src = (m == 2'h0) ? s : (m == 2'h1) ? 24'h0 :
              (m == 2'h2) ? TL : 24'h0 - TL;
        v = $signed({src[23], src}) - $signed({o[23], o});
        // A 25-bit difference overflows 24 bits when its top two differ
        if (v[24] != v[23]) return v[24] ? 24'h800000 : 24'h7FFFFF;
        return v[23:0];
    endfunction : exp_res

    task automatic sam(input logic [23:0] s, e);
        @(posedge clk);
        smp <= s;
        sv <= 1'b1;
        @(posedge clk);
        sv <= 1'b0;
        smp <= ~s;
        @(posedge clk);
        @(negedge clk);
        chk("result_valid", {31'h0, rv}, 32'h1);
        chk("result", {8'h0, res}, {8'h0, e});
    endtask : sam

    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        conclude();
    end

    initial begin
        rst_n = 1'b0;
        {rd, wr, sv, adr, wd, be, smp} = '0;
        gdc = 4'h9;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rdc(10'h088, 16'h0000, 2'h0);
        rdc(10'h08C, 16'h0000, 2'h0);
        rdc(10'h090, 16'h0000, 2'h0);
        acc(1'b1, 10'h088, 16'hFFFF, 4'hF);
        rdc(10'h088, 16'hFFC7, 2'h0);
        chk("phase", {22'h0, ph}, 32'h3FF);
        chk("selector", {30'h0, sel}, 32'h3);
        chk("dc", {28'h0, dcf}, 32'h0);
        acc(1'b1, 10'h088, 16'h8000, 4'h2);
        rdc(10'h088, 16'h80C7, 2'h0);
        acc(1'b1, 10'h088, 16'h7F41, 4'h1);
        rdc(10'h088, 16'h8041, 2'h0);
        chk("phase", {22'h0, ph}, 32'h201);
        chk("dc", {28'h0, dcf}, 32'h9);
        gdc <= 4'h5;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("dc", {28'h0, dcf}, 32'h5);
        acc(1'b1, 10'h08C, 16'h1234, 4'h3);
        acc(1'b1, 10'h090, 16'h56FF, 4'h3);
        rdc(10'h090, 16'h5600, 2'h0);
        rdc(10'h08C, 16'h1234, 2'h0);
        chk("offset", {8'h0, ocal}, 32'h123456);
        acc(1'b1, 10'h094, 16'hFFFF, 4'h3);
        chk("response", {30'h0, gresp}, {30'h0, 2'h3});
        rdc(10'h094, 16'h0000, 2'h3);
        rdc(10'h08C, 16'h1234, 2'h0);
        for (int k = 0; k < 3; k++) begin
            acc(1'b1, 10'h08C, ofs[k][23:8], 4'h3);
            acc(1'b1, 10'h090, {ofs[k][7:0], 8'h00}, 4'h3);
            for (int m = 0; m < 4; m++) begin
                acc(1'b1, 10'h088, {14'h0, 2'(m)}, 4'h1);
                sam(sps[k], exp_res(2'(m), sps[k], ofs[k]));
            end
        end
        // Mid-run reset must bring config and offset registers back to zero; dc output follows the global setting
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("phase", {22'h0, ph}, 32'h0);
        chk("offset", {8'h0, ocal}, 32'h0);
        rdc(10'h088, 16'h0000, 2'h0);
        rdc(10'h090, 16'h0000, 2'h0);
        chk("dc", {28'h0, dcf}, 32'h5);
        conclude();
    end
endmodule : ccr_channel_regs_tb_top
